// >>> gdps_host.sv
// memory controller end: drives reset, CKE, select and mode commands
`timescale 1ns/1ps
module gdps_host #(
   parameter int DATA_RATE  = 2666,
   parameter int CAS_LAT    = 18,
   parameter int CAS_WR_LAT = 14,
   parameter bit USE_EXTRAS = 1'b0
) (
   input  wire logic clk_in,
   input  wire logic rst_in,
   gdps_if.host      link,
   input  wire logic init_req_in,
   input  wire logic gear_req_in,
   input  wire logic sre_req_in,
   input  wire logic srx_req_in,
   input  wire logic mps_enter_req_in,
   input  wire logic mps_stay_req_in,
   input  wire logic mps_exit_req_in,
   output logic      ready_out,
   output logic      gear_out,
   output logic      refused_out,
   output logic [7:0] add_lat_out
);
   import gdps_pkg::*;

   typedef enum logic [13:0] {
      H_IDLE = 14'h0001, H_RST  = 14'h0002, H_CKE  = 14'h0004, H_SYNC = 14'h0008,
      H_CMDW = 14'h0010, H_RDY  = 14'h0020, H_SR   = 14'h0040, H_SRXW = 14'h0080,
      H_MPE  = 14'h0100, H_MPS  = 14'h0200, H_BLIP = 14'h0400, H_MPXR = 14'h0800,
      H_MPXN = 14'h1000, H_MPXD = 14'h2000
   } gdps_hst_type;

   // gear-down only for fast grades with even latencies
   localparam bit GEAR_OK = (DATA_RATE >= GEAR_MIN_RATE) && (CAS_LAT % 2 == 0)
                            && (CAS_WR_LAT % 2 == 0);
   localparam logic [7:0] AL_2N = 8'(CAS_LAT - 2);

   gdps_hst_type     st_r;
   gdps_hst_type     st_nxt;
   logic [TW-1:0]    hc_r;
   logic             t_ld;
   logic [TW-1:0]    t_val;
   logic             t_done;
   logic             gear_nxt;
   logic             ref_nxt;
   logic             rst_n_nxt;
   logic             cke_nxt;
   logic             cs_n_nxt;
   logic [2:0]       cmd_nxt;
   logic [MR_AW-1:0] addr_nxt;
   logic [MR_DW-1:0] data_nxt;
   logic             slow_nxt;
   logic             pda_nxt;
   logic             ext_nxt;
   logic             ck_nxt;

   gdps_cnt #(.W(TW)) u_timer (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .load_in  (t_ld),
      .val_in   (t_val),
      .done_out (t_done)
   );

   // sequencing; the bus defaults to deselect every cycle
   always_comb
   begin
      st_nxt    = st_r;
      t_ld      = 1'b0;
      t_val     = '0;
      gear_nxt  = gear_out;
      ref_nxt   = 1'b0;
      rst_n_nxt = link.reset_n;
      cke_nxt   = link.cke;
      cs_n_nxt  = 1'b1;
      cmd_nxt   = CMD_NOP;
      addr_nxt  = '0;
      data_nxt  = '0;
      slow_nxt  = 1'b0;
      pda_nxt   = 1'b0;
      ext_nxt   = link.extras_on;
      ck_nxt    = link.ck_en;
      case (st_r)
         H_IDLE:
            if (init_req_in)
            begin
               st_nxt    = H_RST;
               rst_n_nxt = 1'b0;
               cke_nxt   = 1'b0;
               t_ld      = 1'b1;
               t_val     = C_RESET;
            end
         H_RST:
            if (t_done)
            begin
               st_nxt    = H_CKE;
               rst_n_nxt = 1'b1;
               cke_nxt   = 1'b1;
            end
         H_CKE, H_SRXW:
            if ((st_r == H_CKE) || t_done)
            begin
               if (gear_req_in && GEAR_OK)
               begin
                  // slow gear write; nothing but refresh precedes it after exit
                  st_nxt   = H_SYNC;
                  cs_n_nxt = 1'b0;
                  cmd_nxt  = CMD_MRS;
                  addr_nxt = GEAR_MR;
                  data_nxt = MR_DW'(1) << GEAR_BIT;
                  slow_nxt = 1'b1;
                  ext_nxt  = 1'b0;
               end
               else
               begin
                  st_nxt  = H_RDY;
                  ref_nxt = gear_req_in;
               end
            end
         H_SYNC:
            if (hc_r == C_SYNC - TW'(1))
            begin
               st_nxt   = H_CMDW;
               cs_n_nxt = 1'b0;
               cmd_nxt  = CMD_NOP;
               slow_nxt = 1'b1;
               t_ld     = 1'b1;
               t_val    = C_CMD + TW'(1);
            end
         H_CMDW:
            if (t_done)
            begin
               st_nxt   = H_RDY;
               gear_nxt = 1'b1;
               ext_nxt  = USE_EXTRAS;
            end
         H_RDY:
            if (sre_req_in)
            begin
               // the only way back to 1N
               st_nxt   = H_SR;
               cs_n_nxt = 1'b0;
               cmd_nxt  = CMD_SRE;
               gear_nxt = 1'b0;
            end
            else if (mps_enter_req_in)
            begin
               if (gear_out || link.extras_on)
               begin
                  ref_nxt = 1'b1;
                  ext_nxt = 1'b0;
               end
               else
               begin
                  st_nxt   = H_MPE;
                  cs_n_nxt = 1'b0;
                  cmd_nxt  = CMD_MRS;
                  addr_nxt = MPS_MR;
                  data_nxt = MR_DW'(1) << MPS_BIT;
                  pda_nxt  = 1'b1;
                  t_ld     = 1'b1;
                  t_val    = C_CKMPE;
               end
            end
         H_SR:
            if (srx_req_in)
            begin
               st_nxt   = H_SRXW;
               cs_n_nxt = 1'b0;
               cmd_nxt  = CMD_SRX;
               t_ld     = 1'b1;
               t_val    = C_XS;
            end
         H_MPE:
            if (t_done)
            begin
               st_nxt = H_MPS;
               ck_nxt = 1'b0;
            end
         H_MPS:
            if (mps_exit_req_in)
            begin
               st_nxt  = H_MPXR;
               ck_nxt  = 1'b1;
               cke_nxt = 1'b0;
               t_ld    = 1'b1;
               t_val   = C_CKMPX;
            end
            else if (mps_stay_req_in)
            begin
               st_nxt  = H_BLIP;
               cke_nxt = 1'b0;
            end
         H_BLIP:
         begin
            st_nxt  = H_MPS;
            cke_nxt = 1'b1;
         end
         H_MPXR:
            if (t_done)
            begin
               st_nxt   = H_MPXN;
               cke_nxt  = 1'b1;
               cs_n_nxt = 1'b0;
               t_ld     = 1'b1;
               t_val    = C_MPX_LH;
            end
         H_MPXN:
         begin
            cs_n_nxt = 1'b0;
            if (t_done)
            begin
               st_nxt   = H_MPXD;
               cs_n_nxt = 1'b1;
               t_ld     = 1'b1;
               t_val    = C_XMP;
            end
         end
         H_MPXD:
            if (t_done)
               st_nxt = H_RDY;
         default:
            st_nxt = H_IDLE;
      endcase
   end

   // state and sync edge counter
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         st_r <= H_IDLE;
         hc_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
         hc_r <= (st_r == H_SYNC) ? hc_r + TW'(1) : '0;
      end
   end

   // link and user outputs, all registered
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         link.reset_n   <= 1'b0;
         link.cke       <= 1'b0;
         link.cs_n      <= 1'b1;
         link.cmd       <= CMD_NOP;
         link.mr_addr   <= '0;
         link.mr_data   <= '0;
         link.slow      <= 1'b0;
         link.pda_sel   <= 1'b0;
         link.extras_on <= 1'b0;
         link.ck_en     <= 1'b1;
         ready_out      <= 1'b0;
         gear_out       <= 1'b0;
         refused_out    <= 1'b0;
         add_lat_out    <= '0;
      end
      else
      begin
         link.reset_n   <= rst_n_nxt;
         link.cke       <= cke_nxt;
         link.cs_n      <= cs_n_nxt;
         link.cmd       <= cmd_nxt;
         link.mr_addr   <= addr_nxt;
         link.mr_data   <= data_nxt;
         link.slow      <= slow_nxt;
         link.pda_sel   <= pda_nxt;
         link.extras_on <= ext_nxt;
         link.ck_en     <= ck_nxt;
         ready_out      <= (st_nxt == H_RDY);
         gear_out       <= gear_nxt;
         refused_out    <= ref_nxt;
         add_lat_out    <= gear_nxt ? AL_2N : 8'h00;
      end
   end
endmodule : gdps_host

// >>> gdps_pkg.sv
// constants and types shared by both ends of the gear-down / power-save sequencer
package gdps_pkg;
   localparam int              CLK_MHZ   = 100;
   localparam int              TW        = 16;
   localparam int              MR_AW     = 3;
   localparam int              MR_DW     = 14;
   // command codes, valid only while chip select is low
   localparam logic [2:0]      CMD_NOP   = 3'h0;
   localparam logic [2:0]      CMD_MRS   = 3'h1;
   localparam logic [2:0]      CMD_REF   = 3'h2;
   localparam logic [2:0]      CMD_SRE   = 3'h3;
   localparam logic [2:0]      CMD_SRX   = 3'h4;
   localparam logic [2:0]      CMD_OTH   = 3'h5;
   // mode register fields
   localparam logic [MR_AW-1:0] GEAR_MR  = 3'h3;
   localparam int              GEAR_BIT  = 3;
   localparam logic [MR_AW-1:0] MPS_MR   = 3'h4;
   localparam int              MPS_BIT   = 1;
   localparam int              GEAR_MIN_RATE = 2666;
   // timing in ns
   localparam int T_SYNC_GEAR_NS = 40;
   localparam int T_CMD_GEAR_NS  = 40;
   localparam int T_DLLK_NS      = 2000;
   localparam int T_XS_NS        = 300;
   localparam int T_XSDLL_NS     = 2000;
   localparam int T_MPED_NS      = 150;
   localparam int T_CKMPE_NS     = 150;
   localparam int T_CKMPX_NS     = 100;
   localparam int T_MPX_LH_NS    = 50;
   localparam int T_XMP_NS       = 300;
   localparam int T_XMP_DLL_NS   = 2000;
   localparam int T_RESET_NS     = 200;
   // least time to whole cycles, never below one
   function automatic int cyc_min(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : cyc_min
   // sync wait rounded up to an even count so the sync pulse lands on an even edge
   localparam logic [TW-1:0] C_SYNC   = TW'((cyc_min(T_SYNC_GEAR_NS) + 1) / 2 * 2);
   localparam logic [TW-1:0] C_CMD    = TW'(cyc_min(T_CMD_GEAR_NS));
   localparam logic [TW-1:0] C_DLLK   = TW'(cyc_min(T_DLLK_NS));
   localparam logic [TW-1:0] C_XS     = TW'(cyc_min(T_XS_NS));
   localparam logic [TW-1:0] C_XSDLL  = TW'(cyc_min(T_XSDLL_NS));
   localparam logic [TW-1:0] C_MPED   = TW'(cyc_min(T_MPED_NS));
   localparam logic [TW-1:0] C_CKMPE  = TW'(cyc_min(T_CKMPE_NS));
   localparam logic [TW-1:0] C_CKMPX  = TW'(cyc_min(T_CKMPX_NS));
   localparam logic [TW-1:0] C_MPX_LH = TW'(cyc_min(T_MPX_LH_NS));
   localparam logic [TW-1:0] C_XMP    = TW'(cyc_min(T_XMP_NS));
   localparam logic [TW-1:0] C_XMPDLL = TW'(cyc_min(T_XMP_DLL_NS));
   localparam logic [TW-1:0] C_RESET  = TW'(cyc_min(T_RESET_NS));
   typedef enum logic [9:0] {
      D_OFF  = 10'h001, D_INIT = 10'h002, D_SYNC = 10'h004, D_CMDW = 10'h008,
      D_RUN  = 10'h010, D_SR   = 10'h020, D_SRX  = 10'h040, D_MPE  = 10'h080,
      D_MPS  = 10'h100, D_MPX  = 10'h200
   } gdps_dst_type;
endpackage : gdps_pkg

// >>> gdps_if.sv
// command/control link between memory controller and memory device
`timescale 1ns/1ps
interface gdps_if;
   import gdps_pkg::*;
   logic                 reset_n;
   logic                 cke;
   logic                 cs_n;
   logic [2:0]           cmd;
   logic [MR_AW-1:0]     mr_addr;
   logic [MR_DW-1:0]     mr_data;
   logic                 slow;
   logic                 pda_sel;
   logic                 extras_on;
   logic                 ck_en;
   modport dev (input reset_n, cke, cs_n, cmd, mr_addr, mr_data, slow, pda_sel,
                extras_on, ck_en);
   modport host (output reset_n, cke, cs_n, cmd, mr_addr, mr_data, slow, pda_sel,
                 extras_on, ck_en);
endinterface : gdps_if

// >>> gdps_cnt.sv
// down counter for wait times; done while the count is zero
`timescale 1ns/1ps
module gdps_cnt #(
   parameter int W = 16
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic         load_in,
   input  wire logic [W-1:0] val_in,
   output logic              done_out
);
   logic [W-1:0] count_r;
   // reload wins over counting so a fresh wait always starts whole
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         count_r <= '0;
      else if (load_in)
         count_r <= val_in;
      else if (count_r != '0)
         count_r <= count_r - W'(1);
   end
   assign done_out = (count_r == '0);
endmodule : gdps_cnt

// >>> gdps_dev.sv
// memory device end: gear-down clocking and maximum power-saving state
//
// Notes on behaviour
// - power-up and reset run 1N command clocking
// - gear-down only at 2666 or faster
// - gear entry only init or self-refresh exit
// - parity and CAL off around gear entry
// - init: reset, CKE, slow gear MRS, sync
// - sync pulse on even edge, even wait
// - after command wait, continue init in 2N
// - self refresh entry returns clocking to 1N
// - after exit, only refresh before gear MRS
// - non-DLL commands after command wait, DLL later
// - staying 1N after exit needs no sync
// - leave 2N only through self refresh
// - 2N needs even latencies, AL is CL-2
// - power-save keeps no data, ignores commands
// - power-save entered by MRS, per-device select
// - parity, CAL, gear off before power-save entry
// - after entry delay only CKE, CS, reset
// - clock held valid for clock hold time
// - CS high at CKE rise keeps power-save
// - CS low at CKE rise starts exit
// - clock restarted before exit CKE rise
// - NOP during select hold, then DES
`timescale 1ns/1ps
module gdps_dev (
   input  wire logic clk_in,
   input  wire logic rst_in,
   gdps_if.dev       link,
   output logic      gear_2n_out,
   output logic      mps_out,
   output logic      cmd_ok_out,
   output logic      dll_ok_out,
   output logic      reject_out
);
   import gdps_pkg::*;

   gdps_dst_type   state_r;
   gdps_dst_type   state_nxt;
   logic           gear_r;
   logic           gear_nxt;
   logic           mps_r;
   logic           mps_nxt;
   logic           cke_q_r;
   logic [TW-1:0]  edge_r;
   logic           t_ld;
   logic [TW-1:0]  t_val;
   logic           t_done;
   logic           d_ld;
   logic [TW-1:0]  d_val;
   logic           d_done;
   logic           rej;
   logic           cmd_v;
   logic           cke_rise;
   logic           cmd_ok_nxt;

   // a gear-down write: slow MRS to the gear bit with parity and CAL off
   function automatic logic gear_mrs(input logic v, input logic [2:0] c, input logic s,
                                     input logic [MR_AW-1:0] a, input logic [MR_DW-1:0] d,
                                     input logic x);
      return v && (c == CMD_MRS) && s && (a == GEAR_MR) && d[GEAR_BIT] && !x;
   endfunction : gear_mrs

   // any write to the gear register, legal or not
   function automatic logic gear_touch(input logic v, input logic [2:0] c,
                                       input logic [MR_AW-1:0] a);
      return v && (c == CMD_MRS) && (a == GEAR_MR);
   endfunction : gear_touch

   assign cmd_v    = !link.cs_n && link.cke;
   assign cke_rise = link.cke && !cke_q_r;

   // wait timer for command validity and a second one for DLL-dependent commands
   gdps_cnt #(.W(TW)) u_cmd_timer (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .load_in  (t_ld),
      .val_in   (t_val),
      .done_out (t_done)
   );
   gdps_cnt #(.W(TW)) u_dll_timer (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .load_in  (d_ld),
      .val_in   (d_val),
      .done_out (d_done)
   );

   // mode sequencing
   always_comb
   begin
      state_nxt = state_r;
      gear_nxt  = gear_r;
      mps_nxt   = mps_r;
      t_ld      = 1'b0;
      t_val     = '0;
      d_ld      = 1'b0;
      d_val     = '0;
      rej       = 1'b0;
      if (!link.reset_n)
      begin
         // reset wins in every state, power-save included
         state_nxt = D_OFF;
         gear_nxt  = 1'b0;
         mps_nxt   = 1'b0;
      end
      else
      begin
         case (state_r)
            D_OFF:
               if (link.cke)
               begin
                  state_nxt = D_INIT;
                  d_ld      = 1'b1;
                  d_val     = C_DLLK;
               end
            D_INIT:
               if (gear_mrs(cmd_v, link.cmd, link.slow, link.mr_addr, link.mr_data,
                            link.extras_on))
                  state_nxt = D_SYNC;
               else if (gear_touch(cmd_v, link.cmd, link.mr_addr))
                  rej = 1'b1;
               else if (cmd_v && (link.cmd != CMD_NOP))
                  state_nxt = D_RUN;
            // only a slow NOP on an even edge from the gear write is the sync pulse
            D_SYNC:
               if (cmd_v && link.slow && (link.cmd == CMD_NOP))
               begin
                  if (!edge_r[0] && (edge_r >= C_SYNC))
                  begin
                     state_nxt = D_CMDW;
                     gear_nxt  = 1'b1;
                     t_ld      = 1'b1;
                     t_val     = C_CMD;
                     d_ld      = 1'b1;
                     d_val     = C_DLLK;
                  end
                  else
                     rej = 1'b1;
               end
            D_CMDW, D_MPX:
               if (t_done)
                  state_nxt = D_RUN;
            // after exit only refresh may precede the gear write; the first other command
            // closes that window once the exit wait has run out and is carried out, bar a rejected gear or power-save MRS; during the wait it is rejected
            D_RUN, D_SRX:
               if ((state_r == D_SRX) && !t_done && cmd_v && (link.cmd != CMD_NOP)
                   && (link.cmd != CMD_REF))
                  rej = 1'b1;
               else if ((state_r == D_SRX) && gear_mrs(cmd_v, link.cmd, link.slow,
                        link.mr_addr, link.mr_data, link.extras_on))
                  state_nxt = D_SYNC;
               else if (cmd_v && (link.cmd == CMD_SRE))
               begin
                  state_nxt = D_SR;
                  gear_nxt  = 1'b0;
               end
               else if (gear_touch(cmd_v, link.cmd, link.mr_addr))
                  rej = 1'b1;
               else if (cmd_v && (link.cmd == CMD_MRS) && (link.mr_addr == MPS_MR)
                        && link.mr_data[MPS_BIT] && link.pda_sel)
               begin
                  // parity, CAL or gear still on would spoil the exit hold
                  if (link.extras_on || gear_r)
                     rej = 1'b1;
                  else
                  begin
                     state_nxt = D_MPE;
                     mps_nxt   = 1'b1;
                     t_ld      = 1'b1;
                     t_val     = C_MPED;
                  end
               end
               else if (cmd_v && (link.cmd != CMD_NOP) && (link.cmd != CMD_REF))
                  state_nxt = D_RUN;
            D_SR:
               if (cmd_v && (link.cmd == CMD_SRX))
               begin
                  state_nxt = D_SRX;
                  t_ld      = 1'b1;
                  t_val     = C_XS;
                  d_ld      = 1'b1;
                  d_val     = C_XSDLL;
               end
            D_MPE:
               if (t_done)
                  state_nxt = D_MPS;
            // clock is not trusted here; only the CKE rising edge samples select
            D_MPS:
               if (cke_rise && !link.cs_n)
               begin
                  state_nxt = D_MPX;
                  mps_nxt   = 1'b0;
                  t_ld      = 1'b1;
                  t_val     = C_XMP;
                  d_ld      = 1'b1;
                  d_val     = C_XMPDLL;
               end
            default:
               state_nxt = D_OFF;
         endcase
      end
   end

   // state, gear and power-save bits
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         state_r <= D_OFF;
         gear_r  <= 1'b0;
         mps_r   <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         gear_r  <= gear_nxt;
         mps_r   <= mps_nxt;
      end
   end

   // edges since the gear write; reloaded to one outside the sync wait
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         edge_r <= '0;
      else if (state_r != D_SYNC)
         edge_r <= TW'(1);
      else if (edge_r != '1)
         edge_r <= edge_r + TW'(1);
   end

   // cke history for the clockless exit sampling
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         cke_q_r <= 1'b0;
      else
         cke_q_r <= link.cke;
   end

   // command validity; power-save states accept nothing, and a timer load in the same
   // cycle means the exit wait has only just begun, whatever the old count says
   assign cmd_ok_nxt = (state_nxt == D_INIT) || (state_nxt == D_RUN) ||
                       ((state_nxt == D_SRX) && t_done && !t_ld);

   // registered user outputs
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         cmd_ok_out  <= 1'b0;
         dll_ok_out  <= 1'b0;
         reject_out  <= 1'b0;
         gear_2n_out <= 1'b0;
         mps_out     <= 1'b0;
      end
      else
      begin
         cmd_ok_out  <= cmd_ok_nxt;
         dll_ok_out  <= cmd_ok_nxt && d_done && !d_ld;
         reject_out  <= rej;
         gear_2n_out <= gear_nxt;
         mps_out     <= mps_nxt;
      end
   end
endmodule : gdps_dev

// >>> gdps_props.sv
// checker on the host/device link of the gear-down / power-save sequencer
`timescale 1ns/1ps
module gdps_props (
   input wire logic                      clk_in,
   input wire logic                      rst_in,
   input wire logic                      reset_n,
   input wire logic                      cke,
   input wire logic                      cs_n,
   input wire logic [2:0]                cmd,
   input wire logic [gdps_pkg::MR_AW-1:0] mr_addr,
   input wire logic [gdps_pkg::MR_DW-1:0] mr_data,
   input wire logic                      slow,
   input wire logic                      pda_sel,
   input wire logic                      extras_on,
   input wire logic                      ck_en
);
   import gdps_pkg::*;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // decoded mode writes; a command only counts while selected and enabled
   wire logic sel_c = !cs_n && cke;
   wire logic gmrs  = sel_c && cmd == CMD_MRS && mr_addr == GEAR_MR && mr_data[GEAR_BIT];
   wire logic pmrs  = sel_c && cmd == CMD_MRS && mr_addr == MPS_MR && mr_data[MPS_BIT];
   chk_mps_no_extras: assert property (pmrs |-> !extras_on)
      else $error("power-save entry with extras on");
   chk_mps_pda_sel: assert property (pmrs |-> pda_sel)
      else $error("power-save entry without device select");
   chk_gear_slow_clean: assert property (gmrs |-> slow && !extras_on)
      else $error("gear write not slow or extras on");
   chk_cke_after_reset: assert property (!reset_n |-> !cke)
      else $error("cke high while device reset low");
   // sync pulse must land four edges after the gear write, deselects between
   chk_sync_even_edge: assert property (gmrs |=> cs_n [*3] ##1 (!cs_n && cmd == CMD_NOP && slow))
      else $error("sync pulse not on the even edge");
   chk_clock_hold: assert property (pmrs |=> ck_en [*8])
      else $error("clock stopped too early after entry");
   chk_clock_restart: assert property ($rose(cke) && !cs_n |-> $past(ck_en) && $past(ck_en, 8))
      else $error("exit edge without restarted clock");
   chk_exit_nop_hold: assert property ($rose(cke) && !cs_n |-> (!cs_n && cmd == CMD_NOP) [*6] ##1 cs_n)
      else $error("exit select hold not NOP then deselect");
   cover property (gmrs);
   cover property (pmrs);
   cover property ($rose(cke) && !cs_n);
endmodule : gdps_props

// >>> tb_top.sv
// self-checking bench joining host and device ends
`timescale 1ns/1ps
module tb_top;
   import gdps_pkg::*;
   localparam int CL = 18;
   logic       clk_in = 1'b0;
   logic       rst_in = 1'b1;
   logic       rst_h  = 1'b0;
   logic       rej_seen = 1'b0;
   logic       gear   = 1'b1;
   logic [5:0] req    = 6'h00;
   logic       ready, gear_h, refused, g2n, mps, cmd_ok, dll_ok, rej;
   logic [7:0] add_lat;
   int         n_errors = 0;
   int         n_checks = 0;
   gdps_if link ();
   gdps_host #(.CAS_LAT(CL)) u_gdps_host (.clk_in(clk_in), .rst_in(rst_in || rst_h),
      .link(link.host),
      .init_req_in(req[0]), .gear_req_in(gear), .sre_req_in(req[1]), .srx_req_in(req[2]),
      .mps_enter_req_in(req[3]), .mps_stay_req_in(req[4]), .mps_exit_req_in(req[5]),
      .ready_out(ready), .gear_out(gear_h), .refused_out(refused), .add_lat_out(add_lat));
   gdps_dev u_gdps_dev (.clk_in(clk_in), .rst_in(rst_in), .link(link.dev), .gear_2n_out(g2n),
      .mps_out(mps), .cmd_ok_out(cmd_ok), .dll_ok_out(dll_ok), .reject_out(rej));
   gdps_props u_gdps_props (.clk_in(clk_in), .rst_in(rst_in), .reset_n(link.reset_n),
      .cke(link.cke), .cs_n(link.cs_n), .cmd(link.cmd), .mr_addr(link.mr_addr),
      .mr_data(link.mr_data), .slow(link.slow), .pda_sel(link.pda_sel),
      .extras_on(link.extras_on), .ck_en(link.ck_en));
   initial forever #5 clk_in = ~clk_in;
   // a legal host never provokes a device reject, so any pulse is kept for the end
   always @(posedge clk_in)
      if (!rst_in && rej !== 1'b0)
         rej_seen <= 1'b1;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // all stimulus moves 1 ns after a rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : cyc
   // pulse stops right after the taking edge so a one-cycle refusal is still seen
   task automatic pulse(input int k);
      req[k] = 1'b1;
      cyc(1);
      req[k] = 1'b0;
   endtask : pulse
   function automatic logic pick(input int k);
      return (k == 0) ? ready : (k == 1) ? dll_ok : refused;
   endfunction : pick
   task automatic wt(input int k, input int n);
      for (int i = 0; i < n && pick(k) !== 1'b1; i++) cyc(1);
   endtask : wt
   task automatic t_init(input logic g);
      gear = g;
      pulse(0);
      cyc(2);
      wt(0, 3000);
      chk(8'(gear_h), {7'h00, g}, "gear_out");
      chk(8'(g2n), {7'h00, g}, "gear_2n_out");
      chk(add_lat, g ? 8'(CL - 2) : 8'h00, "add_lat_out");
      chk(8'(cmd_ok), 8'h01, "cmd_ok_out");
      wt(1, 400);
      chk(8'(dll_ok), 8'h01, "dll_ok_out");
   endtask : t_init
   task automatic t_refuse;
      pulse(3);
      wt(2, 10);
      chk(8'(refused), 8'h01, "refused_out");
      chk(8'(mps), 8'h00, "mps_out refused");
   endtask : t_refuse
   // back to 1N only through self refresh
   task automatic t_sref;
      gear = 1'b0;
      pulse(1);
      cyc(5);
      chk(8'(g2n), 8'h00, "gear_2n_out in sr");
      pulse(2);
      cyc(1);
      chk(8'(cmd_ok), 8'h00, "cmd_ok_out in exit wait");
      wt(0, 3000);
      // device validity follows the host's ready by one edge
      cyc(1);
      chk(8'(g2n), 8'h00, "gear_2n_out after srx");
      chk(8'(cmd_ok), 8'h01, "cmd_ok_out after srx");
   endtask : t_sref
   task automatic t_mps;
      pulse(3);
      cyc(30);
      chk(8'(mps), 8'h01, "mps_out entered");
      pulse(4);
      cyc(10);
      chk(8'(mps), 8'h01, "mps_out stay");
      pulse(5);
      cyc(2);
      wt(0, 3000);
      chk(8'(mps), 8'h00, "mps_out exit");
      chk(8'(cmd_ok), 8'h01, "cmd_ok_out exit");
   endtask : t_mps
   task automatic report_and_stop;
      if (n_errors == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   initial
   begin
      cyc(6);
      rst_in = 1'b0;
      cyc(1);
      t_init(1'b1);
      t_refuse();
      t_sref();
      t_mps();
      pulse(3);
      cyc(30);
      chk(8'(mps), 8'h01, "mps_out before reset");
      // host-only reset pulls the link reset low while the device sleeps
      rst_h = 1'b1;
      cyc(2);
      rst_h = 1'b0;
      chk({5'h00, g2n, mps, cmd_ok}, 8'h00, "device after reset");
      t_init(1'b0);
      chk(8'(rej_seen), 8'h00, "reject_out");
      report_and_stop();
   end
   // a hang is cut short well past the expected run length
   initial
   begin
      #200000;
      n_errors++;
      report_and_stop();
   end
endmodule : tb_top
